/* hdl/adc_conversion_timing_sequencer.sv */
// Conversion timing sequencer: sample, ten approximation steps, result load.
// Assumes the analog comparator output is asynchronous and a start pulse
// comes from logic on clk_sys.
//
// Behaviour
// - Sample phase runs before any digitising
// - Ten successive approximation steps, one per bit
// - Phase durations programmable in CPU clock multiples
// - Timing from two 2-bit selectors, upper nibble
// - Durations counted in half CPU periods
// - Sample, compare and extra phases make conversion
// - Selector 00 phase duration table
// - Selector 11 phase duration table
// - Selector 10 phase duration table
// - Input changes ignored after sampling ends
// - Clamped inputs give all-zero or all-ones code
// - Power-off bit disables the converter
`timescale 1ns/10ps
module adc_conversion_timing_sequencer (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Control
  input  wire logic [7:0] converter_control_reg,
  input  wire logic       convStart,
  // Analog front end
  input  wire logic       compHigh,
  output logic            sampleSwitch,
  output logic            holdActive,
  output logic [9:0]      dacCode,
  output logic            analogPowerOn,
  // Result
  output logic [9:0]      result,
  output logic            resultValid,
  output logic            busy
);
  // Table row for a selector pair; 01 treated as 00
  function automatic logic [3:0] tableIndex(input logic [1:0] ctc, input logic [1:0] stc);
    logic [1:0] row;
    row = (ctc == 2'b11) ? 2'd1 : (ctc == 2'b10) ? 2'd2 : 2'd0;
    return 4'(row * 4 + stc);
  endfunction

  function automatic logic [10:0] cycles(input int hp);
    return 11'(hp / adc_seq_pkg::HALF_PER_CLK);
  endfunction

  logic [1:0]  convClockSelect;
  logic [1:0]  sampleTimeSelect;
  logic        converterPowerOff;
  assign convClockSelect   = converter_control_reg[adc_seq_pkg::CTC_POS +: 2];
  assign sampleTimeSelect  = converter_control_reg[adc_seq_pkg::STC_POS +: 2];
  assign converterPowerOff = converter_control_reg[adc_seq_pkg::OFF_POS];

  adc_seq_pkg::seq_state_t state_ff;
  logic [3:0]  idx_ff;
  logic [10:0] cnt_ff;
  logic [3:0]  bit_ff;
  logic [9:0]  sar_ff;
  logic        comp1_ff, comp2_ff, comp3_ff;
  logic        lastCycle;
  logic [10:0] stepLen;
  logic [10:0] sampleLen;
  logic [10:0] extraLen;

  // Comparator input crosses domains; second and third stage must agree
  logic compStable_ff;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      comp1_ff <= 1'b0;
      comp2_ff <= 1'b0;
      comp3_ff <= 1'b0;
      compStable_ff <= 1'b0;
    end else begin
      comp1_ff <= compHigh;
      comp2_ff <= comp1_ff;
      comp3_ff <= comp2_ff;
      if (comp2_ff == comp3_ff)
        compStable_ff <= comp3_ff;
    end
  end

  always_comb begin
    sampleLen = cycles(adc_seq_pkg::SAMPLE_HP[idx_ff]);
    stepLen   = cycles(adc_seq_pkg::COMPARE_HP[idx_ff]) / 11'(adc_seq_pkg::RES_BITS);
    extraLen  = cycles(adc_seq_pkg::EXTRA_HP[idx_ff]);
  end
  assign lastCycle = (cnt_ff == 11'd1);

  // Phase sequencing; selectors latched at start so a mid-run write is harmless
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_ff <= adc_seq_pkg::ST_IDLE;
      idx_ff   <= 4'h0;
      cnt_ff   <= 11'h000;
      bit_ff   <= 4'h0;
    end else if (converterPowerOff) begin
      state_ff <= adc_seq_pkg::ST_IDLE;
      cnt_ff   <= 11'h000;
    end else begin
      case (state_ff)
        adc_seq_pkg::ST_IDLE: begin
          if (convStart) begin
            idx_ff   <= tableIndex(convClockSelect, sampleTimeSelect);
            cnt_ff   <= cycles(adc_seq_pkg::SAMPLE_HP[tableIndex(convClockSelect,
                                                                  sampleTimeSelect)]);
            state_ff <= adc_seq_pkg::ST_SAMPLE;
          end
        end
        adc_seq_pkg::ST_SAMPLE: begin
          if (lastCycle) begin
            state_ff <= adc_seq_pkg::ST_COMPARE;
            cnt_ff   <= stepLen;
            bit_ff   <= 4'(adc_seq_pkg::RES_BITS - 1);
          end else
            cnt_ff <= cnt_ff - 11'd1;
        end
        adc_seq_pkg::ST_COMPARE: begin
          if (lastCycle) begin
            cnt_ff <= stepLen;
            if (bit_ff == 4'h0) begin
              state_ff <= adc_seq_pkg::ST_EXTRA;
              cnt_ff   <= extraLen;
            end else
              bit_ff <= bit_ff - 4'h1;
          end else
            cnt_ff <= cnt_ff - 11'd1;
        end
        adc_seq_pkg::ST_EXTRA: begin
          if (lastCycle)
            state_ff <= adc_seq_pkg::ST_DONE;
          else
            cnt_ff <= cnt_ff - 11'd1;
        end
        adc_seq_pkg::ST_DONE:
          state_ff <= adc_seq_pkg::ST_IDLE;
        default:
          state_ff <= adc_seq_pkg::ST_IDLE;
      endcase
    end
  end

  // Successive approximation register; trial bit set, kept if input above DAC
  always_ff @(posedge clk_sys) begin
    if (rst)
      sar_ff <= adc_seq_pkg::CODE_MIN;
    else if (state_ff == adc_seq_pkg::ST_SAMPLE && lastCycle)
      sar_ff <= 10'h200;
    else if (state_ff == adc_seq_pkg::ST_COMPARE && lastCycle) begin
      // Decision uses the held voltage only; the sampling switch is open
      sar_ff[bit_ff] <= compStable_ff;
      if (bit_ff != 4'h0)
        sar_ff[bit_ff - 4'h1] <= 1'b1;
    end
  end

  // Result load at end of the extra phase
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      result      <= adc_seq_pkg::CODE_MIN;
      resultValid <= 1'b0;
    end else begin
      resultValid <= 1'b0;
      if (state_ff == adc_seq_pkg::ST_EXTRA && lastCycle && !converterPowerOff) begin
        // Clamp happens naturally: all decisions 0 or all 1
        result      <= sar_ff;
        resultValid <= 1'b1;
      end
    end
  end

  assign sampleSwitch  = (state_ff == adc_seq_pkg::ST_SAMPLE);
  assign holdActive    = (state_ff == adc_seq_pkg::ST_COMPARE) ||
                         (state_ff == adc_seq_pkg::ST_EXTRA);
  assign dacCode       = sar_ff;
  assign analogPowerOn = !converterPowerOff;
  assign busy          = (state_ff != adc_seq_pkg::ST_IDLE);

  // Helper: cycles spent in sample phase
  logic [11:0] sampCount_ff;
  always_ff @(posedge clk_sys) begin
    if (rst)
      sampCount_ff <= 12'h000;
    else if (state_ff == adc_seq_pkg::ST_SAMPLE)
      sampCount_ff <= sampCount_ff + 12'h001;
    else
      sampCount_ff <= 12'h000;
  end

  sequence startSeq;
    state_ff == adc_seq_pkg::ST_IDLE && convStart && !converterPowerOff;
  endsequence

  start_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
    startSeq |=> sampleSwitch && !holdActive)
    else $error("sample phase did not follow start");

  sample_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(sampleSwitch) && !$past(converterPowerOff) |->
      sampCount_ff == 12'(sampleLen))
    else $error("sample phase length wrong");

  no_hold_sample_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(sampleSwitch && holdActive))
    else $error("sampling while holding");

  power_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    converterPowerOff |-> !analogPowerOn ##1 !busy)
    else $error("converter active while powered off");

  extra_done_a: assert property (@(posedge clk_sys) disable iff (rst)
    state_ff == adc_seq_pkg::ST_EXTRA && lastCycle && !converterPowerOff |=> resultValid)
    else $error("result not loaded after extra phase");

  result_src_a: assert property (@(posedge clk_sys) disable iff (rst)
    resultValid |-> result == $past(sar_ff))
    else $error("result differs from approximation register");

  fallback_a: assert property (@(posedge clk_sys) disable iff (rst)
    startSeq && convClockSelect == 2'b01 |=>
      idx_ff == {2'b00, $past(sampleTimeSelect)})
    else $error("reserved selector not mapped to default");

  step_len_a: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(holdActive) && state_ff == adc_seq_pkg::ST_COMPARE |->
      cnt_ff == stepLen && bit_ff == 4'h9)
    else $error("compare phase started wrongly");
endmodule

/* inc/adc_seq_pkg.sv */
// Constants for the conversion timing sequencer.
// Assumes one system clock; durations are in half-CPU-period units.
package adc_seq_pkg;
  localparam int CLK_HZ              = 25000000;
  localparam int RES_BITS            = 10;
  // Converter control byte: selectors in the upper nibble, power-off at bit 3
  localparam int CTRL_WIDTH          = 8;
  localparam int CTC_POS             = 6;
  localparam int STC_POS             = 4;
  localparam int OFF_POS             = 3;
  localparam logic [7:0] CTRL_RESET  = 8'h00;
  // One system clock is one CPU period, that is two half-period units
  localparam int HALF_PER_CLK        = 2;
  localparam logic [9:0] CODE_MIN    = 10'h000;
  localparam logic [9:0] CODE_MAX    = 10'h3ff;
  // Durations in half-period units: index [ctc_row*4 + stc]; rows 00, 11, 10
  localparam int SAMPLE_HP [12] = '{120, 140, 200, 400, 240, 280, 400, 800,
                                    480, 560, 800, 1600};
  localparam int COMPARE_HP [12] = '{240, 280, 280, 280, 480, 560, 560, 560,
                                     960, 1120, 1120, 1120};
  localparam int EXTRA_HP [12]  = '{28, 16, 52, 44, 52, 28, 100, 52,
                                    100, 52, 196, 164};
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_SAMPLE  = 3'b001,
    ST_COMPARE = 3'b010,
    ST_EXTRA   = 3'b011,
    ST_DONE    = 3'b100
  } seq_state_t;
endpackage

/* bench/analog_source_model.sv */
// Analog input source and reference seen through the comparator.
// Assumes the bench sets the input level in LSB steps, clamped levels allowed.
`timescale 1ns/10ps
module analog_source_model (
  // Clock
  input  wire logic               clk_sys,
  // Sequencer side
  input  wire logic               sampleSwitch,
  input  wire logic               holdActive,
  input  wire logic               analogPowerOn,
  input  wire logic [9:0]         dacCode,
  output logic                    compHigh,
  // Stimulus
  input  wire logic signed [15:0] level
);
  int   heldLevel  = 0;
  logic idleToggle = 1'b0;

  // Capacitor tracks the input only while the switch is closed
  always_ff @(posedge clk_sys) begin
    if (sampleSwitch) begin
      heldLevel <= level;
    end
    idleToggle <= ~idleToggle;
  end

  // Level sits half an LSB above its code; out-of-range levels saturate
  // Comparator output is meaningless outside hold, so it wanders then
  assign compHigh = (holdActive && analogPowerOn) ?
                    (heldLevel * 2 + 1 > int'(dacCode) * 2) : idleToggle;
endmodule

/* bench/adc_conversion_timing_sequencer_bench.sv */
// Bench for the conversion timing sequencer with an analog source model.
// Assumes a 25 MHz clk_sys and durations from the package tables.
`timescale 1ns/10ps
module adc_conversion_timing_sequencer_bench;
  logic               clk_sys;
  logic               rst;
  logic [7:0]         ctrl;
  logic               convStart;
  logic               compHigh;
  logic               sampleSwitch;
  logic               holdActive;
  logic               analogPowerOn;
  logic               resultValid;
  logic               busy;
  logic [9:0]         dacCode;
  logic [9:0]         result;
  logic signed [15:0] level;
  int                 num_errors = 0;
  int                 checks     = 0;
  int                 cycles     = 0;
  logic [1:0]         ctcList [3] = '{2'h0, 2'h3, 2'h2};

  adc_conversion_timing_sequencer uut (.clk_sys(clk_sys), .rst(rst),
    .converter_control_reg(ctrl), .convStart(convStart), .compHigh(compHigh),
    .sampleSwitch(sampleSwitch), .holdActive(holdActive), .dacCode(dacCode),
    .analogPowerOn(analogPowerOn), .result(result), .resultValid(resultValid),
    .busy(busy));
  analog_source_model source (.clk_sys(clk_sys), .sampleSwitch(sampleSwitch),
    .holdActive(holdActive), .analogPowerOn(analogPowerOn), .dacCode(dacCode),
    .compHigh(compHigh), .level(level));

  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end

  task automatic complete_run;
    if (num_errors == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] expv, input logic [31:0] got);
    checks++;
    if (got !== expv) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", what, expv, got);
    end
  endtask

  // Second start mid-run must be ignored; input moves once hold begins
  task automatic run_conv(input logic [1:0] ctc, input logic [1:0] stc, input int lvl,
                          input int lvl2, input logic [9:0] expCode);
    int idx, n, nSam, nHold, s, c, e;
    idx = ((ctc == 2'h3) ? 4 : (ctc == 2'h2) ? 8 : 0) + stc;
    s = adc_seq_pkg::SAMPLE_HP[idx] / 2;
    c = adc_seq_pkg::COMPARE_HP[idx] / 2;
    e = adc_seq_pkg::EXTRA_HP[idx] / 2;
    level = 16'(lvl);
    ctrl = {ctc, stc, 4'h0};
    convStart = 1'b1;
    @(negedge clk_sys);
    convStart = 1'b0;
    chk("busy", 32'h1, busy);
    n = 0; nSam = 0; nHold = 0;
    while (resultValid !== 1'b1 && n < 1600) begin
      if (holdActive === 1'b1 && nHold == 0) begin
        chk("first trial", 32'h200, dacCode);
        level = 16'(lvl2);
      end
      if (sampleSwitch === 1'b1) nSam++;
      if (holdActive === 1'b1) nHold++;
      convStart = (n == 5);
      @(negedge clk_sys);
      n++;
    end
    chk("sample cycles", s, nSam);
    chk("hold cycles", c + e, nHold);
    chk("latency", s + c + e, n);
    chk("result", expCode, result);
    @(negedge clk_sys);
    chk("busy end", 32'h0, busy);
  endtask

  task automatic power_abort;
    int seen;
    ctrl = 8'h08;
    convStart = 1'b1;
    @(negedge clk_sys);
    chk("power on", 32'h0, analogPowerOn);
    chk("start refused", 32'h0, busy);
    ctrl = 8'h00;
    @(negedge clk_sys);
    convStart = 1'b0;
    repeat (80) @(negedge clk_sys);
    ctrl = 8'h08;
    seen = 0;
    repeat (300) begin
      @(negedge clk_sys);
      if (resultValid !== 1'b0) seen++;
    end
    chk("aborted busy", 32'h0, busy);
    chk("no result", 32'h0, seen);
    ctrl = 8'h00;
    @(negedge clk_sys);
    chk("power back", 32'h1, analogPowerOn);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end

  initial begin
    rst = 1'b1;
    ctrl = 8'h00;
    convStart = 1'b0;
    level = 16'sh0;
    repeat (16) @(negedge clk_sys);
    rst = 1'b0;
    @(negedge clk_sys);
    for (int r = 0; r < 3; r++) begin
      for (int s = 0; s < 4; s++) begin
        run_conv(ctcList[r], 2'(s), 300 + 37 * s + 101 * r, 1000 - 90 * s,
                 10'(300 + 37 * s + 101 * r));
      end
    end
    run_conv(2'h1, 2'h2, 700, 5, 10'h2bc);
    run_conv(2'h0, 2'h0, -40, 900, 10'h000);
    run_conv(2'h0, 2'h3, 5000, 0, 10'h3ff);
    power_abort();
    complete_run();
  end
endmodule
